// ===== hw/ppc_defines.svh
// Constants for the partition priority configuration bank.
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

`define PPC_ADDR_W          12
`define PPC_SEL_OFFSET      12'h100
`define PPC_PRI_OFFSET      12'h400
`define PPC_SEL_PART_MSB    15
`define PPC_SEL_NARROW_BIT  16
`define PPC_SEL_RIS_LSB     24
`define PPC_SEL_RIS_MSB     27
`define PPC_INNER_LSB       0
`define PPC_DS_LSB          16
`define PPC_FIELD_W         16
`define PPC_INNER_WD        8
`define PPC_DS_WD           4
`define PPC_NUM_WORLDS      4
`define PPC_PART_IDX_W      3
`define PPC_RIS_IDX_W       1
`define PPC_ENTRY_IDX_W     6
`define PPC_NUM_ENTRIES     64
`define PPC_INNER_MASK      16'h00FF
`define PPC_DS_MASK         16'h000F
`define PPC_ZERO32          32'h0000_0000

`endif

// ===== hw/ppc_pkg.sv
// Types shared by the partition priority configuration bank.
package ppc_pkg;

   typedef enum logic [1:0] {
      PPC_SECURE    = 2'b00,
      PPC_NONSECURE = 2'b01,
      PPC_ROOT      = 2'b10,
      PPC_REALM     = 2'b11
   } ppc_world_t;

endpackage

// ===== hw/ppc_priority_bank.sv
// Per-partition priority register bank with selector and lookup port.
`timescale 1ns/10ps
`include "ppc_defines.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module ppc_priority_bank
   import ppc_pkg::*;
(
   // Clock and reset.
   input  wire logic                     i_clock,
   input  wire logic                     i_rst_b,
   // Register access port, one request per cycle.
   input  wire logic                     i_acc_valid,
   input  wire logic                     i_acc_write,
   input  wire ppc_world_t               i_acc_world,
   input  wire logic [`PPC_ADDR_W-1:0]   i_acc_addr,
   input  wire logic [31:0]              i_acc_wdata,
   output logic                          o_acc_ready,
   output logic [31:0]                   o_acc_rdata,
   // Static capability straps.
   input  wire logic                     i_priority_partitioning_present,
   input  wire logic                     i_inner_prio_present,
   input  wire logic                     i_downstream_prio_present,
   input  wire logic                     i_inner_zero_lowest,
   input  wire logic                     i_downstream_zero_lowest,
   input  wire logic                     i_instance_select_present,
   input  wire logic                     i_narrowing_present,
   input  wire logic                     i_four_world_security_option,
   // Request priority lookup.
   input  wire ppc_world_t               i_lookup_world,
   input  wire logic [`PPC_RIS_IDX_W-1:0]  i_lookup_ris,
   input  wire logic [`PPC_PART_IDX_W-1:0] i_lookup_partition,
   output logic [`PPC_FIELD_W-1:0]       o_inner_priority,
   output logic [`PPC_FIELD_W-1:0]       o_downstream_priority,
   // Error status.
   input  wire logic                     i_error_clear,
   output logic                          o_range_error
);

   logic [`PPC_NUM_WORLDS-1:0][31:0]     sel_reg;
   logic [`PPC_NUM_ENTRIES-1:0][31:0]    prio_store;
   logic [31:0]                          sel_cur;
   logic [31:0]                          wr_mask;
   logic [`PPC_FIELD_W-1:0]              inner_mask;
   logic [`PPC_FIELD_W-1:0]              ds_mask;
   logic [`PPC_RIS_IDX_W-1:0]            acc_ris;
   logic [`PPC_ENTRY_IDX_W-1:0]          acc_idx;
   logic [`PPC_ENTRY_IDX_W-1:0]          look_idx;
   logic                                 world_ok;
   logic                                 part_ok;
   logic                                 sel_hit;
   logic                                 pri_hit;
   logic                                 narrow_err;
   logic                                 pri_wr;
   logic [31:0]                          rdata_next;
   logic [31:0]                          look_raw;
   logic [`PPC_FIELD_W-1:0]              inner_raw;
   logic [`PPC_FIELD_W-1:0]              ds_raw;

   ////////////////////////////////////////////////////////////////////////
   // Decode.

   assign inner_mask = i_inner_prio_present ?
                       `PPC_INNER_MASK : 16'h0000;
   assign ds_mask    = i_downstream_prio_present ?
                       `PPC_DS_MASK : 16'h0000;
   assign wr_mask    = {ds_mask, inner_mask};

   // The upper worlds are cut off from the access port without the four-world option; the lookup port still serves them.
   assign world_ok = (i_acc_world == PPC_SECURE) ||
                     (i_acc_world == PPC_NONSECURE) ||
                     i_four_world_security_option;
   assign sel_cur  = sel_reg[i_acc_world];
   assign acc_ris  = i_instance_select_present ?
                     sel_cur[`PPC_SEL_RIS_LSB +: `PPC_RIS_IDX_W] :
                     {`PPC_RIS_IDX_W{1'b0}};
   assign part_ok  =
      (sel_cur[`PPC_SEL_PART_MSB:`PPC_PART_IDX_W] == '0);
   assign acc_idx  = {i_acc_world, acc_ris,
                      sel_cur[`PPC_PART_IDX_W-1:0]};

   always_comb begin
      sel_hit = 1'b0;
      pri_hit = 1'b0;
      if (i_acc_valid && world_ok &&
          i_acc_addr == `PPC_SEL_OFFSET) begin
         sel_hit = 1'b1;
      end else if (i_acc_valid && world_ok &&
                   i_acc_addr == `PPC_PRI_OFFSET &&
                   i_priority_partitioning_present) begin
         pri_hit = 1'b1;
      end
   end

   // With narrowing present, software must set the narrowed flag before touching priorities.
   assign narrow_err = pri_hit && i_narrowing_present &&
                       !sel_cur[`PPC_SEL_NARROW_BIT];
   assign pri_wr     = pri_hit && i_acc_write && part_ok &&
                       !narrow_err;

   ////////////////////////////////////////////////////////////////////////
   // Selector registers, one per security state.

   genvar w;
   generate
      for (w = 0; w < `PPC_NUM_WORLDS; w = w + 1) begin : g_sel
         always_ff @(posedge i_clock) begin
            if (!i_rst_b) begin
               sel_reg[w] <= `PPC_ZERO32;
            end else if (sel_hit && i_acc_write &&
                         i_acc_world == ppc_world_t'(w)) begin
               sel_reg[w] <= `PPC_ZERO32;
               sel_reg[w][`PPC_SEL_PART_MSB:0] <=
                  i_acc_wdata[`PPC_SEL_PART_MSB:0];
               sel_reg[w][`PPC_SEL_NARROW_BIT] <=
                  i_acc_wdata[`PPC_SEL_NARROW_BIT] &&
                  i_narrowing_present;
               if (i_instance_select_present) begin
                  sel_reg[w][`PPC_SEL_RIS_LSB +: `PPC_RIS_IDX_W] <=
                     i_acc_wdata[`PPC_SEL_RIS_LSB +: `PPC_RIS_IDX_W];
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Priority storage, one word per state, instance and partition.

   genvar e;
   generate
      for (e = 0; e < `PPC_NUM_ENTRIES; e = e + 1) begin : g_entry
         always_ff @(posedge i_clock) begin
            if (!i_rst_b) begin
               prio_store[e] <= `PPC_ZERO32;
            end else if (pri_wr &&
                         acc_idx == `PPC_ENTRY_IDX_W'(e)) begin
               prio_store[e] <= i_acc_wdata & wr_mask;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read data and acknowledge, answered one cycle after the request.

   always_comb begin
      rdata_next = `PPC_ZERO32;
      if (sel_hit) begin
         // Fields of absent options read as zero, whatever is stored.
         rdata_next = sel_cur;
         rdata_next[`PPC_SEL_RIS_LSB +: `PPC_RIS_IDX_W] = acc_ris;
         rdata_next[`PPC_SEL_NARROW_BIT] =
            sel_cur[`PPC_SEL_NARROW_BIT] && i_narrowing_present;
      end else if (pri_hit && part_ok && !narrow_err) begin
         // Masking on read keeps stale bits hidden after a strap change.
         rdata_next = prio_store[acc_idx] & wr_mask;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_acc_ready <= 1'b0;
         o_acc_rdata <= `PPC_ZERO32;
      end else begin
         o_acc_ready <= i_acc_valid;
         o_acc_rdata <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky range error; a new error wins over a clear in the same cycle.

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_range_error <= 1'b0;
      end else if (narrow_err) begin
         o_range_error <= 1'b1;
      end else if (i_error_clear) begin
         o_range_error <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lookup: values leave normalised so that a larger value is more urgent.

   assign look_idx  = {i_lookup_world,
                       i_instance_select_present ? i_lookup_ris :
                       {`PPC_RIS_IDX_W{1'b0}},
                       i_lookup_partition};
   assign look_raw  = prio_store[look_idx];
   assign inner_raw = look_raw[`PPC_INNER_LSB +: `PPC_FIELD_W] & inner_mask;
   assign ds_raw    = look_raw[`PPC_DS_LSB +: `PPC_FIELD_W] & ds_mask;

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_inner_priority      <= '0;
         o_downstream_priority <= '0;
      end else begin
         o_inner_priority <= i_inner_zero_lowest ? inner_raw :
                             (~inner_raw & inner_mask);
         o_downstream_priority <= i_downstream_zero_lowest ? ds_raw :
                                  (~ds_raw & ds_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   property p_ack_next;
      i_acc_valid |=> o_acc_ready;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("Access not acknowledged in the next cycle.");

   property p_ds_unused;
      !i_downstream_prio_present ##1 !i_downstream_prio_present
         |=> o_downstream_priority == '0;
   endproperty
   a_ds_unused: assert property (p_ds_unused)
      else $error("Downstream priority driven while absent.");

   property p_inner_unused;
      !i_inner_prio_present ##1 !i_inner_prio_present
         |=> o_inner_priority == '0;
   endproperty
   a_inner_unused: assert property (p_inner_unused)
      else $error("Inner priority driven while absent.");

   property p_width_limit;
      o_inner_priority[`PPC_FIELD_W-1:`PPC_INNER_WD] == '0 &&
      o_acc_rdata[31:`PPC_DS_LSB + `PPC_DS_WD] == '0 ||
      $past(sel_hit);
   endproperty
   a_width_limit: assert property (p_width_limit)
      else $error("Bits above implemented width are nonzero.");

   property p_err_flag;
      narrow_err |=> o_range_error;
   endproperty
   a_err_flag: assert property (p_err_flag)
      else $error("Range error not recorded.");

   property p_err_no_write;
      narrow_err && i_acc_write |=> $stable(prio_store);
   endproperty
   a_err_no_write: assert property (p_err_no_write)
      else $error("Store changed on a rejected write.");

   property p_absent_raz;
      i_acc_valid && i_acc_addr == `PPC_PRI_OFFSET &&
      !i_priority_partitioning_present
         |=> o_acc_rdata == `PPC_ZERO32 && $stable(prio_store);
   endproperty
   a_absent_raz: assert property (p_absent_raz)
      else $error("Absent priority register not read-as-zero.");

   property p_root_blocked;
      i_acc_valid && i_acc_world == PPC_ROOT &&
      !i_four_world_security_option
         |=> o_acc_rdata == `PPC_ZERO32 && $stable(prio_store);
   endproperty
   a_root_blocked: assert property (p_root_blocked)
      else $error("Root instance reachable without option.");

   property p_ris_hidden;
      sel_hit && !i_acc_write && !i_instance_select_present
         |=> o_acc_rdata[`PPC_SEL_RIS_MSB:`PPC_SEL_RIS_LSB] == '0;
   endproperty
   a_ris_hidden: assert property (p_ris_hidden)
      else $error("Instance index visible while selection is absent.");

   c_pri_write: cover property (pri_wr ##1 o_acc_ready);
   c_pri_read: cover property (pri_hit && !i_acc_write ##1
                               o_acc_rdata != `PPC_ZERO32);
   c_range_err: cover property (narrow_err ##1 o_range_error);
   c_err_clear: cover property (o_range_error && i_error_clear ##1
                                !o_range_error);
   c_lookup_inv: cover property (!i_inner_zero_lowest ##1
                                 o_inner_priority != '0);

endmodule // ppc_priority_bank

// ===== verification/ppc_host_model.sv
// Software model that issues register accesses to the priority bank.
`timescale 1ns/10ps
`include "ppc_defines.svh"
module ppc_host_model
   import ppc_pkg::*;
(
   // Clock.
   input  wire logic                  i_clock,
   // Access request toward the bank.
   output logic                       o_acc_valid,
   output logic                       o_acc_write,
   output ppc_world_t                 o_acc_world,
   output logic [`PPC_ADDR_W-1:0]     o_acc_addr,
   output logic [31:0]                o_acc_wdata,
   // Answer from the bank.
   input  wire logic                  i_acc_ready,
   input  wire logic [31:0]           i_acc_rdata
);
   initial begin
      o_acc_valid = 1'b0;
      o_acc_write = 1'b0;
      o_acc_world = PPC_SECURE;
      o_acc_addr  = 12'h000;
      o_acc_wdata = 32'h0000_0000;
   end

   // One access; valid stands one cycle, since each high cycle is an access.
   task automatic access(input logic wr, input ppc_world_t wld,
      input logic [`PPC_ADDR_W-1:0] adr, input logic [31:0] wd,
      output logic [31:0] rd, output logic ok);
      int n;
      @(posedge i_clock);
      #1;
      o_acc_valid = 1'b1;
      o_acc_write = wr;
      o_acc_world = wld;
      o_acc_addr  = adr;
      o_acc_wdata = wd;
      @(posedge i_clock);
      #1;
      o_acc_valid = 1'b0;
      // Released address and data toggle so a stale value never looks like a request.
      o_acc_addr  = ~o_acc_addr;
      o_acc_wdata = ~o_acc_wdata;
      ok = 1'b0;
      rd = 32'h0000_0000;
      for (n = 0; n < 4 && !ok; n++) begin
         if (i_acc_ready === 1'b1) begin
            rd = i_acc_rdata;
            ok = 1'b1;
         end else begin
            @(posedge i_clock);
            #1;
         end
      end
   endtask
endmodule // ppc_host_model

// ===== verification/partition_priority_config_test.sv
// Self-checking testbench for the partition priority bank.
`timescale 1ns/10ps
module partition_priority_config_test;
   import ppc_pkg::*;
   logic              clock = 1'b0;
   logic              rst_b = 1'b0;
   logic [7:0]        straps = 8'hBF;
   ppc_world_t        lk_world = PPC_SECURE;
   logic              lk_ris = 1'b0;
   logic [2:0]        lk_part = 3'h0;
   logic              err_clr = 1'b0;
   logic              valid, write, ready, range_err;
   ppc_world_t        world;
   logic [11:0]       addr;
   logic [31:0]       wdata, rdata, rd, d, mem [4][2][8];
   logic [15:0]       inner_pri, ds_pri;
   int                fails = 0, n_compared = 0, seed = 82554, i, w, r, p;

   always #50 clock = ~clock;

   ppc_host_model host (.i_clock(clock), .o_acc_valid(valid),
      .o_acc_write(write), .o_acc_world(world), .o_acc_addr(addr),
      .o_acc_wdata(wdata), .i_acc_ready(ready), .i_acc_rdata(rdata));

   ppc_priority_bank DUT (.i_clock(clock), .i_rst_b(rst_b),
      .i_acc_valid(valid), .i_acc_write(write), .i_acc_world(world),
      .i_acc_addr(addr), .i_acc_wdata(wdata), .o_acc_ready(ready),
      .o_acc_rdata(rdata), .i_priority_partitioning_present(straps[0]),
      .i_inner_prio_present(straps[1]), .i_downstream_prio_present(straps[2]),
      .i_inner_zero_lowest(straps[3]), .i_downstream_zero_lowest(straps[4]),
      .i_instance_select_present(straps[5]), .i_narrowing_present(straps[6]),
      .i_four_world_security_option(straps[7]), .i_lookup_world(lk_world),
      .i_lookup_ris(lk_ris), .i_lookup_partition(lk_part),
      .o_inner_priority(inner_pri), .o_downstream_priority(ds_pri),
      .i_error_clear(err_clr), .o_range_error(range_err));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_word(logic [31:0] v);
      exp_word = 32'h0000_0000;
      if (straps[0] && straps[1]) exp_word[7:0] = v[7:0];
      if (straps[0] && straps[2]) exp_word[19:16] = v[19:16];
   endfunction

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(logic wr, int wd, logic [11:0] a, logic [31:0] v);
      logic ok;
      host.access(wr, ppc_world_t'(wd[1:0]), a, v, rd, ok);
      if (!ok) begin
         fails++;
         close_out();
      end
   endtask

   // The narrowed flag is set by software only when narrowing is present.
   task automatic sel(int wd, int pt, int rs);
      acc(1'b1, wd, 12'h100, {7'h00, rs[0], 7'h00, straps[6], 13'h0000,
         pt[2:0]});
   endtask

   // Lookup output is normalised: inverted within width when zero is high.
   task automatic sweep();
      logic [15:0] ei, ed;
      for (i = 0; i < 64; i++) begin
         lk_world = ppc_world_t'(i[5:4]);
         lk_ris = i[3];
         lk_part = i[2:0];
         @(posedge clock);
         #1;
         ei = {8'h00, mem[i[5:4]][i[3]][i[2:0]][7:0]};
         ed = {12'h000, mem[i[5:4]][i[3]][i[2:0]][19:16]};
         check(inner_pri, straps[3] ? ei : ei ^ 16'h00FF);
         check(ds_pri, straps[4] ? ed : ed ^ 16'h000F);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      foreach (mem[a, b, c]) mem[a][b][c] = 32'h0000_0000;
      repeat (20) @(posedge clock);
      #1;
      rst_b = 1'b1;
      sweep();
      for (i = 0; i < 16; i++) begin
         w = $random(seed) & 3;
         r = $random(seed) & 1;
         p = $random(seed) & 7;
         d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
         sel(w, p, r);
         acc(1'b0, w, 12'h100, 32'h0);
         check(rd, {7'h00, r[0], 21'h000000, p[2:0]});
         acc(1'b1, w, 12'h400, d);
         mem[w][r][p] = exp_word(d);
         acc(1'b0, w, 12'h400, 32'h0);
         check(rd, exp_word(d));
      end
      sweep();
      straps = 8'hA7;
      sweep();
      sel(2, 1, 1);
      straps = 8'h3F;
      acc(1'b1, 2, 12'h400, 32'hFFFF_FFFF);
      acc(1'b0, 2, 12'h400, 32'h0);
      check(rd, 32'h0);
      straps = 8'hBF;
      acc(1'b0, 2, 12'h400, 32'h0);
      check(rd, mem[2][1][1]);
      straps = 8'hBE;
      acc(1'b1, 2, 12'h400, 32'hFFFF_FFFF);
      acc(1'b0, 2, 12'h400, 32'h0);
      check(rd, 32'h0);
      for (i = 0; i < 2; i++) begin
         straps = i ? 8'hBB : 8'hBD;
         acc(1'b0, 2, 12'h400, 32'h0);
         check(rd, exp_word(mem[2][1][1]));
      end
      straps = 8'hBF;
      acc(1'b0, 2, 12'h400, 32'h0);
      check(rd, mem[2][1][1]);
      acc(1'b0, 2, 12'h404, 32'h0);
      check(rd, 32'h0);
      straps = 8'h9F;
      acc(1'b0, 2, 12'h100, 32'h0);
      check(rd, 32'h0000_0001);
      acc(1'b0, 2, 12'h400, 32'h0);
      check(rd, mem[2][0][1]);
      straps = 8'hFF;
      acc(1'b1, 1, 12'h100, 32'h0000_0003);
      acc(1'b1, 1, 12'h400, 32'hFFFF_FFFF);
      @(posedge clock);
      #1;
      check({31'h0, range_err}, 32'h1);
      sel(1, 3, 0);
      acc(1'b0, 1, 12'h400, 32'h0);
      check(rd, mem[1][0][3]);
      err_clr = 1'b1;
      @(posedge clock);
      #1;
      err_clr = 1'b0;
      check({31'h0, range_err}, 32'h0);
      close_out();
   end
endmodule // partition_priority_config_test
